// [src/aerf_pkg.sv]
// package: constants and types for the alarm event report formatter
package aerf_pkg;
   localparam int unsigned DIGIT_W   = 4;
   localparam int unsigned MSG_LEN   = 13;
   localparam logic [3:0]  LAST_IDX  = 4'hC;
   localparam logic [3:0]  QUAL_NEW  = 4'hE;
   localparam logic [3:0]  QUAL_RST  = 4'h3;
   localparam int unsigned QUEUE_D   = 4;
   localparam logic [7:0]  PART_SYS  = 8'h00;
   localparam logic [11:0] ZONE_ZERO = 12'h000;

   // event sources, mapped to event codes
   typedef enum logic [4:0] {
      AERF_SRC_FIRE        = 5'h00,
      AERF_SRC_SMOKE_VER   = 5'h01,
      AERF_SRC_WATERFLOW   = 5'h02,
      AERF_SRC_BURG_PERIM  = 5'h03,
      AERF_SRC_BURG_INTER  = 5'h04,
      AERF_SRC_BURG_24H    = 5'h05,
      AERF_SRC_BURG_ENTRY  = 5'h06,
      AERF_SRC_BURG_DAYNT  = 5'h07,
      AERF_SRC_POLL_SHORT  = 5'h08,
      AERF_SRC_RF_SUPV     = 5'h09,
      AERF_SRC_RPM_SUPV    = 5'h0A,
      AERF_SRC_MAINT_HIGH  = 5'h0B,
      AERF_SRC_MAINT_LOW   = 5'h0C,
      AERF_SRC_WALK_TESTED = 5'h0D,
      AERF_SRC_WALK_UNTEST = 5'h0E,
      AERF_SRC_RELAY_FAIL  = 5'h0F,
      AERF_SRC_DSM_SHUNT   = 5'h10,
      AERF_SRC_OPEN_CLOSE  = 5'h11,
      AERF_SRC_AC_LOSS     = 5'h12,
      AERF_SRC_CALLBACK    = 5'h13
   } aerf_src_t;

   typedef enum logic [1:0] {
      AERF_CLS_ALARM   = 2'h0,
      AERF_CLS_TROUBLE = 2'h1,
      AERF_CLS_USER    = 2'h2,
      AERF_CLS_SYSTEM  = 2'h3
   } aerf_cls_t;

   typedef struct packed {
      aerf_src_t   src;
      logic        restore;
      logic        system_wide;
      logic [7:0]  partition;
      logic [11:0] zone_or_user;
   } aerf_event_t;

   typedef struct packed {
      logic [15:0] subscriber_id_field;
      logic [3:0]  qualifier;
      logic [11:0] event_code_field;
      logic [7:0]  partition_field;
      logic [11:0] zone_or_user_field;
      logic        is_alarm;
   } aerf_msg_t;
endpackage

// [src/aerf_code_map.sv]
// module: maps an event source to its event code and class
module aerf_code_map
   import aerf_pkg::*;
(
   // source
   input  aerf_pkg::aerf_src_t src_i,
   // result
   output logic [11:0]         code_o,
   output aerf_pkg::aerf_cls_t cls_o
);
   always_comb begin
      code_o = 12'h000;
      cls_o  = AERF_CLS_SYSTEM;
      unique case (src_i)
         AERF_SRC_FIRE:        begin code_o = 12'h110; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_SMOKE_VER:   begin code_o = 12'h111; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_WATERFLOW:   begin code_o = 12'h113; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_BURG_PERIM:  begin code_o = 12'h131; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_BURG_INTER:  begin code_o = 12'h132; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_BURG_24H:    begin code_o = 12'h133; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_BURG_ENTRY:  begin code_o = 12'h134; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_BURG_DAYNT:  begin code_o = 12'h135; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_POLL_SHORT:  begin code_o = 12'h142; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_RF_SUPV:     begin code_o = 12'h381; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_RPM_SUPV:    begin code_o = 12'h382; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_MAINT_HIGH:  begin code_o = 12'h385; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_MAINT_LOW:   begin code_o = 12'h386; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_WALK_TESTED: begin code_o = 12'h611; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_WALK_UNTEST: begin code_o = 12'h612; cls_o = AERF_CLS_ALARM; end
         AERF_SRC_RELAY_FAIL:  begin code_o = 12'h432; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_DSM_SHUNT:   begin code_o = 12'h434; cls_o = AERF_CLS_TROUBLE; end
         AERF_SRC_OPEN_CLOSE:  begin code_o = 12'h401; cls_o = AERF_CLS_USER; end
         AERF_SRC_AC_LOSS:     begin code_o = 12'h301; cls_o = AERF_CLS_SYSTEM; end
         AERF_SRC_CALLBACK:    begin code_o = 12'h411; cls_o = AERF_CLS_USER; end
         default:              begin code_o = 12'h000; cls_o = AERF_CLS_SYSTEM; end
      endcase
   end
endmodule // aerf_code_map

// [src/aerf_formatter.sv]
// module: alarm event report formatter, one digit at a time to the dialer
module aerf_formatter
   import aerf_pkg::*;
#(
   parameter int unsigned QDEPTH = QUEUE_D
) (
   // clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  nrst_i,
   // configuration
   input  wire logic [15:0]           subscriber_id_i,
   input  wire logic                  open_rpt_en_i,
   // remote session status
   input  wire logic                  session_on_i,
   input  wire logic                  transfer_on_i,
   input  wire logic                  access_ok_i,
   // event input
   input  wire logic                  evt_valid_i,
   input  aerf_pkg::aerf_event_t      evt_i,
   output logic                       evt_ready_o,
   // digit stream to dialer
   output logic                       dig_valid_o,
   output logic [3:0]                 dig_o,
   output logic                       dig_last_o,
   input  wire logic                  dig_ready_i,
   // status
   output logic                       held_full_o
);
   import aerf_pkg::*;

   localparam int unsigned QPW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;

   // pin-level inputs pass two flops
   logic [1:0] sess_sync_ff;
   logic [1:0] xfer_sync_ff;
   logic [1:0] acc_sync_ff;
   logic       acc_prev_ff;
   logic       sess_on;
   logic       xfer_on;
   logic       acc_rise;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sess_sync_ff <= 2'h0;
         xfer_sync_ff <= 2'h0;
         acc_sync_ff  <= 2'h0;
         acc_prev_ff  <= 1'b0;
      end else begin
         sess_sync_ff <= {sess_sync_ff[0], session_on_i};
         xfer_sync_ff <= {xfer_sync_ff[0], transfer_on_i};
         acc_sync_ff  <= {acc_sync_ff[0], access_ok_i};
         acc_prev_ff  <= acc_sync_ff[1];
      end
   end

   assign sess_on  = sess_sync_ff[1];
   assign xfer_on  = xfer_sync_ff[1] & sess_on;
   assign acc_rise = acc_sync_ff[1] & ~acc_prev_ff;

   // message assembly for the event port and for the callback report
   logic [11:0] in_code;
   aerf_cls_t   in_cls;
   aerf_msg_t   in_msg;
   aerf_msg_t   cb_msg;
   logic [11:0] cb_code;

   aerf_code_map u_map (
      .src_i  (evt_i.src),
      .code_o (in_code),
      .cls_o  (in_cls)
   );

   assign in_msg.subscriber_id_field = subscriber_id_i;
   assign in_msg.qualifier           = evt_i.restore ? QUAL_RST : QUAL_NEW;
   assign in_msg.event_code_field    = in_code;
   assign in_msg.partition_field     = evt_i.system_wide ? PART_SYS : evt_i.partition;
   assign in_msg.zone_or_user_field  = (in_cls == AERF_CLS_SYSTEM) ? ZONE_ZERO
                                      : evt_i.zone_or_user;
   assign in_msg.is_alarm            = (in_cls == AERF_CLS_ALARM);

   aerf_code_map u_cb_map (
      .src_i  (AERF_SRC_CALLBACK),
      .code_o (cb_code),
      .cls_o  ()
   );

   assign cb_msg.subscriber_id_field = subscriber_id_i;
   assign cb_msg.qualifier           = QUAL_NEW;
   assign cb_msg.event_code_field    = cb_code;
   assign cb_msg.partition_field     = PART_SYS;
   assign cb_msg.zone_or_user_field  = ZONE_ZERO;
   assign cb_msg.is_alarm            = 1'b0;

   // callback request pending flag, set wins over clear
   logic cb_pend_ff;

   // hold queue
   aerf_msg_t      q_mem_ff [QDEPTH];
   logic [QPW-1:0] q_rd_ff;
   logic [QPW-1:0] q_wr_ff;
   logic [QPW:0]   q_cnt_ff;
   logic           q_full;
   logic           q_empty;

   assign q_full      = (q_cnt_ff == (QPW+1)'(QDEPTH));
   assign q_empty     = (q_cnt_ff == '0);
   assign held_full_o = q_full;

   // serializer
   typedef enum logic [0:0] {
      AERF_ST_IDLE = 1'b0,
      AERF_ST_SEND = 1'b1
   } aerf_state_t;

   aerf_state_t state_ff;
   aerf_msg_t   msg_ff;
   logic [3:0]  idx_ff;
   logic [3:0]  dig_ff;

   wire idle       = (state_ff == AERF_ST_IDLE);
   wire evt_alarm  = in_msg.is_alarm;
   wire evt_trbl   = (in_cls == AERF_CLS_TROUBLE);
   wire evt_drop   = xfer_on & (evt_alarm | evt_trbl);
   wire evt_defer  = sess_on & ~evt_drop & ~evt_alarm;
   wire evt_now    = ~evt_drop & ~evt_defer;
   wire may_send   = idle & ~sess_on;
   wire release_q  = may_send & ~q_empty;
   wire cb_deliver = sess_on | ~q_empty;
   // deferred event, or callback while session is on, goes to queue; so does either while the queue is not empty
   wire evt_to_q   = evt_valid_i & ~evt_drop & (evt_defer | ~q_empty) & ~q_full & ~release_q;
   wire evt_direct = evt_valid_i & evt_now & q_empty & idle & ~cb_pend_ff;
   wire cb_to_q    = cb_pend_ff & ~evt_valid_i & ~q_full & ~release_q & cb_deliver;
   wire cb_direct  = cb_pend_ff & ~evt_valid_i & q_empty & may_send;

   assign evt_ready_o = evt_drop | evt_to_q | evt_direct;

   wire q_push = evt_to_q | cb_to_q;
   wire q_pop  = release_q;
   wire load   = evt_direct | cb_direct | release_q;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cb_pend_ff <= 1'b0;
      end else if (acc_rise & open_rpt_en_i) begin
         cb_pend_ff <= 1'b1;
      end else if (cb_to_q | cb_direct) begin
         cb_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (q_push) begin
         q_mem_ff[q_wr_ff] <= evt_to_q ? in_msg : cb_msg;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_rd_ff  <= '0;
         q_wr_ff  <= '0;
         q_cnt_ff <= '0;
      end else begin
         if (q_push) begin
            q_wr_ff <= (q_wr_ff == QPW'(QDEPTH-1)) ? '0 : q_wr_ff + 1'b1;
         end
         if (q_pop) begin
            q_rd_ff <= (q_rd_ff == QPW'(QDEPTH-1)) ? '0 : q_rd_ff + 1'b1;
         end
         q_cnt_ff <= q_cnt_ff + (QPW+1)'(q_push) - (QPW+1)'(q_pop);
      end
   end

   // digit select, most significant first
   localparam int unsigned MSG_W = DIGIT_W * MSG_LEN;

   aerf_msg_t        nxt_msg;
   logic [MSG_W-1:0] digits;
   logic [5:0]       nxt_lo;
   logic [3:0]       nxt_dig;

   assign nxt_msg = release_q ? q_mem_ff[q_rd_ff] : (evt_direct ? in_msg : cb_msg);
   assign digits  = {msg_ff.subscriber_id_field, msg_ff.qualifier, msg_ff.event_code_field,
                     msg_ff.partition_field, msg_ff.zone_or_user_field};
   // low bit of the following digit, parked on the last digit
   assign nxt_lo  = (idx_ff >= LAST_IDX) ? 6'h00 : 6'(MSG_W - 2*DIGIT_W) - {idx_ff, 2'h0};
   assign nxt_dig = digits[nxt_lo +: 4];

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= AERF_ST_IDLE;
         msg_ff   <= '0;
         idx_ff   <= 4'h0;
         dig_ff   <= 4'h0;
      end else begin
         unique case (state_ff)
            AERF_ST_IDLE: begin
               if (load) begin
                  state_ff <= AERF_ST_SEND;
                  msg_ff   <= nxt_msg;
                  idx_ff   <= 4'h0;
                  dig_ff   <= nxt_msg.subscriber_id_field[15:12];
               end
            end
            AERF_ST_SEND: begin
               if (dig_ready_i) begin
                  if (idx_ff == LAST_IDX) begin
                     state_ff <= AERF_ST_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 4'h1;
                     dig_ff <= nxt_dig;
                  end
               end
            end
         endcase
      end
   end

   assign dig_valid_o = (state_ff == AERF_ST_SEND);
   assign dig_o       = dig_ff;
   assign dig_last_o  = dig_valid_o & (idx_ff == LAST_IDX);
endmodule // aerf_formatter

// [dv/aerf_dialer.sv]
// partner: dialer model collecting digit messages
module aerf_dialer (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   // pacing
   input  wire logic       slow_i,
   // digit stream
   input  wire logic       dig_valid_i,
   input  wire logic [3:0] dig_i,
   input  wire logic       dig_last_i,
   output logic            dig_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] got [$];
   logic [47:0] acc;
   logic [3:0]  cnt;
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dig_ready_o <= 1'b0;
         acc <= 48'h0;
         cnt <= 4'h0;
      end else begin
         dig_ready_o <= slow_i ? ~dig_ready_o : 1'b1;
         if (dig_valid_i && dig_ready_o) begin
            acc <= {acc[43:0], dig_i};
            cnt <= cnt + 4'h1;
            if (dig_last_i) begin
               got.push_back({cnt + 4'h1, 8'h00, acc, dig_i});
               acc <= 48'h0;
               cnt <= 4'h0;
            end
         end
      end
   end
endmodule // aerf_dialer

// [dv/aerf_formatter_props.sv]
// checker: port-level properties of the report formatter
module aerf_formatter_props
   import aerf_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        nrst_i,
   input wire logic [15:0] subscriber_id_i,
   input wire logic        session_on_i,
   input wire logic        transfer_on_i,
   input wire logic        evt_valid_i,
   input wire logic        evt_ready_o,
   input wire logic        dig_valid_o,
   input wire logic [3:0]  dig_o,
   input wire logic        dig_last_o,
   input wire logic        dig_ready_i,
   input wire logic        held_full_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_ff;
   logic [3:0] ses_ff;
   logic [3:0] xfr_ff;
   wire        no_ses  = ~|{ses_ff, session_on_i};
   wire        xfr_all = &{xfr_ff, session_on_i & transfer_on_i};
   wire        no_xfr  = ~|{xfr_ff, transfer_on_i};
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= 4'h0;
         ses_ff <= 4'hF;
         xfr_ff <= 4'h0;
      end else begin
         cnt_ff <= !(dig_valid_o && dig_ready_i) ? cnt_ff : dig_last_o ? 4'h0 : cnt_ff + 4'h1;
         ses_ff <= {ses_ff[2:0], session_on_i};
         xfr_ff <= {xfr_ff[2:0], session_on_i & transfer_on_i};
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_digit_held: assert property (dig_valid_o && !dig_ready_i |=>
      dig_valid_o && $stable(dig_o) && $stable(dig_last_o))
      else $error("digit changed before accept");
   a_sub_first: assert property ($rose(dig_valid_o) |-> dig_o == subscriber_id_i[15:12])
      else $error("message does not open with subscriber digit");
   a_qual_digit: assert property (dig_valid_o && cnt_ff == 4'h4 |-> dig_o == QUAL_NEW || dig_o == QUAL_RST)
      else $error("fifth digit not a qualifier");
   a_last_index: assert property (dig_valid_o |-> dig_last_o == (cnt_ff == LAST_IDX))
      else $error("last flag not on final digit");
   a_start_now: assert property (evt_valid_i && evt_ready_o && !dig_valid_o && no_ses && !held_full_o
      |=> dig_valid_o)
      else $error("direct event not started next cycle");
   a_full_refuse: assert property (held_full_o && no_xfr |-> !evt_ready_o)
      else $error("event taken with hold queue full");
   a_xfer_quiet: assert property ($rose(dig_valid_o) |-> !xfr_all)
      else $error("message started during transfer");
   a_held_release: assert property ($fell(session_on_i) && held_full_o |-> ##[1:8] dig_valid_o)
      else $error("held reports not released");
   c_full: cover property ($rose(held_full_o));
   c_stall: cover property (dig_valid_o && !dig_ready_i);
   c_drop: cover property (evt_valid_i && evt_ready_o && xfr_all);
   c_release: cover property ($fell(session_on_i) && held_full_o);
endmodule // aerf_formatter_props

bind aerf_formatter aerf_formatter_props u_props (.clock_i, .nrst_i, .subscriber_id_i, .session_on_i,
   .transfer_on_i, .evt_valid_i, .evt_ready_o, .dig_valid_o, .dig_o, .dig_last_o, .dig_ready_i, .held_full_o);

// [dv/tb_top.sv]
// testbench: drives events and session state, judges the digit stream
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import aerf_pkg::*;
   logic        clock_i, nrst_i, open_rpt_en_i, session_on_i, transfer_on_i, access_ok_i;
   logic        evt_valid_i, evt_ready_o, dig_valid_o, dig_last_o, dig_ready_i, held_full_o, slow;
   logic [3:0]  dig_o;
   logic [15:0] subscriber_id_i;
   aerf_event_t evt_i;
   int          n_tests, n_mismatch;
   logic [11:0] codes [19] = '{12'h110, 12'h111, 12'h113, 12'h131, 12'h132, 12'h133, 12'h134, 12'h135,
      12'h142, 12'h381, 12'h382, 12'h385, 12'h386, 12'h611, 12'h612, 12'h432, 12'h434, 12'h401, 12'h301};
   aerf_formatter dut (.clock_i, .nrst_i, .subscriber_id_i, .open_rpt_en_i, .session_on_i, .transfer_on_i,
      .access_ok_i, .evt_valid_i, .evt_i, .evt_ready_o, .dig_valid_o, .dig_o, .dig_last_o, .dig_ready_i,
      .held_full_o);
   aerf_dialer p (.clock_i, .nrst_i, .slow_i(slow), .dig_valid_i(dig_valid_o), .dig_i(dig_o),
      .dig_last_i(dig_last_o), .dig_ready_o(dig_ready_i));
   task automatic results;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tmo;
      n_mismatch++;
      $display("BAD %0t wait ran out", $time);
      results();
   endtask
   function automatic logic [63:0] mk(logic [11:0] c, logic r, logic [7:0] g, logic [11:0] z);
      return {4'(MSG_LEN), 8'h00, subscriber_id_i, r ? QUAL_RST : QUAL_NEW, c, g, z};
   endfunction
   task automatic send(input aerf_src_t s, input logic r, input logic w, input logic [7:0] g, input logic [11:0] z);
      int k = 0;
      evt_valid_i = 1'b1;
      evt_i = '{s, r, w, g, z};
      #1;
      while (evt_ready_o !== 1'b1) begin
         if (++k > 500) tmo();
         @(negedge clock_i);
      end
      @(negedge clock_i);
      evt_valid_i = 1'b0;
      @(negedge clock_i);
   endtask
   task automatic expm(input logic [63:0] e);
      int k = 0;
      while (p.got.size() == 0) begin
         if (++k > 500) tmo();
         @(negedge clock_i);
      end
      chk(p.got.pop_front(), e);
   endtask
   task automatic t_codes;
      logic [11:0] z;
      logic [7:0]  g;
      for (int i = 0; i < 19; i++) begin
         z = (i == 13 || i == 14) ? ZONE_ZERO : i[0] ? 12'h305 : 12'h017;
         g = (i == 18) ? PART_SYS : 8'h07;
         slow = i[2];
         send(aerf_src_t'(i), i[1], i == 18, 8'h07, z);
         expm(mk(codes[i], i[1], g, i == 18 ? ZONE_ZERO : z));
      end
      $display("done codes");
   endtask
   task automatic t_callback;
      slow = 1'b0;
      open_rpt_en_i = 1'b1;
      access_ok_i = 1'b1;
      repeat (3) @(negedge clock_i);
      access_ok_i = 1'b0;
      expm(mk(12'h411, 1'b0, PART_SYS, ZONE_ZERO));
      open_rpt_en_i = 1'b0;
      access_ok_i = 1'b1;
      repeat (3) @(negedge clock_i);
      access_ok_i = 1'b0;
      repeat (60) @(negedge clock_i);
      chk(64'(p.got.size()), 64'h0);
      $display("done callback");
   endtask
   task automatic t_session;
      int k = 0;
      session_on_i = 1'b1;
      repeat (5) @(negedge clock_i);
      send(AERF_SRC_BURG_INTER, 1'b0, 1'b0, 8'h02, 12'h021);
      expm(mk(12'h132, 1'b0, 8'h02, 12'h021));
      send(AERF_SRC_OPEN_CLOSE, 1'b0, 1'b0, 8'h02, 12'h005);
      transfer_on_i = 1'b1;
      repeat (5) @(negedge clock_i);
      send(AERF_SRC_FIRE, 1'b0, 1'b0, 8'h01, 12'h009);
      send(AERF_SRC_RF_SUPV, 1'b0, 1'b0, 8'h01, 12'h00A);
      send(AERF_SRC_AC_LOSS, 1'b1, 1'b1, 8'h01, 12'h000);
      send(AERF_SRC_OPEN_CLOSE, 1'b1, 1'b0, 8'h03, 12'h006);
      transfer_on_i = 1'b0;
      send(AERF_SRC_OPEN_CLOSE, 1'b0, 1'b0, 8'h04, 12'h007);
      // queue now full: this offer must wait for the session to end
      evt_valid_i = 1'b1;
      evt_i = '{AERF_SRC_AC_LOSS, 1'b0, 1'b1, 8'h04, 12'h000};
      repeat (40) @(negedge clock_i);
      chk(64'(p.got.size()), 64'h0);
      chk({63'h0, held_full_o}, 64'h1);
      chk({63'h0, evt_ready_o}, 64'h0);
      slow = 1'b1;
      session_on_i = 1'b0;
      while (evt_ready_o !== 1'b1) begin
         if (++k > 500) tmo();
         @(negedge clock_i);
      end
      @(negedge clock_i);
      evt_valid_i = 1'b0;
      expm(mk(12'h401, 1'b0, 8'h02, 12'h005));
      expm(mk(12'h301, 1'b1, PART_SYS, ZONE_ZERO));
      expm(mk(12'h401, 1'b1, 8'h03, 12'h006));
      expm(mk(12'h401, 1'b0, 8'h04, 12'h007));
      expm(mk(12'h301, 1'b0, PART_SYS, ZONE_ZERO));
      repeat (60) @(negedge clock_i);
      chk(64'(p.got.size()), 64'h0);
      $display("done session");
   endtask
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   initial begin
      {nrst_i, open_rpt_en_i, session_on_i, transfer_on_i, access_ok_i, evt_valid_i, slow} = 7'h00;
      subscriber_id_i = 16'h4A7C;
      evt_i = '0;
      n_tests = 0;
      n_mismatch = 0;
      repeat (16) @(negedge clock_i);
      nrst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      t_codes();
      t_callback();
      t_session();
      results();
   end
endmodule // tb_top
